// ### core/acd_defines.svh
// constant set for the acquisition command decoder
// assumes inclusion by the design modules and the testbench only
`ifndef ACD_DEFINES_SVH
`define ACD_DEFINES_SVH

// command identifiers
`define ACD_CMD_MODE_WR    16'h0003
`define ACD_CMD_MODE_RD    16'h0004
`define ACD_CMD_SCOPE_WR   16'h0005
`define ACD_CMD_SCOPE_RD   16'h0006
`define ACD_CMD_ACTION_WR  16'h0007
`define ACD_CMD_ACTION_RD  16'h0008
`define ACD_CMD_TRGMASK_WR 16'h0009
`define ACD_CMD_TDC_WR     16'h0101
`define ACD_CMD_TDC_RD     16'h0102
`define ACD_CMD_ADC_RST    16'h0103
`define ACD_CMD_ADC_WR     16'h0104
`define ACD_CMD_DAC_WR     16'h0106
`define ACD_CMD_FWTH_WR    16'h0108
`define ACD_CMD_FWTH_RD    16'h0109

// payload values
`define ACD_MODE_SCOPE     32'h0000_0001
`define ACD_MODE_SINGLES   32'h0000_0002
`define ACD_ACT_RESET      32'h0000_0000
`define ACD_ACT_STOP       32'h0000_0001
`define ACD_ACT_RUN        32'h0000_0002
`define ACD_TDC_RESET      32'h0000_0080
`define ACD_TDC_CALIB      32'h0000_0002
`define ACD_TDC_RUN        32'h0000_0004
`define ACD_DAC_ENERGY_PFX 8'h80
`define ACD_DAC_TIMING_PFX 8'h88

// address field layout
`define ACD_ADDR_BCAST_BIT 15
`define ACD_ADDR_BOARD_MSB 14

// scope settings fields: window [27:24], pretrigger [19:16], samples [11:8]
`define ACD_SCP_WIN_LSB    24
`define ACD_SCP_BTG_LSB    16
`define ACD_SCP_SMP_LSB    8
`define ACD_SCP_SMP_UNIT   16

// apb register map (byte addresses)
`define ACD_REG_CMD_ID     12'h000
`define ACD_REG_CMD_ADDR   12'h004
`define ACD_REG_CMD_PLD    12'h008
`define ACD_REG_CMD_GO     12'h00C
`define ACD_REG_RSP_ID     12'h010
`define ACD_REG_RSP_ADDR   12'h014
`define ACD_REG_RSP_PLD    12'h018
`define ACD_REG_STATUS     12'h01C
`define ACD_REG_BOARD_ID   12'h020

// reset value of board_id, and the fixed reply address
`define ACD_RST_BOARD_ID   15'h0000
`define ACD_RST_SRC_ADDR   16'h4000

`endif

// ### core/acd_pkg.sv
// types shared by the command decoder and its executor
// assumes acd_defines.svh on the include path
package acd_pkg;
	typedef enum logic [2:0] {
		ACD_ACQ_IDLE = 3'b001,
		ACD_ACQ_RUN  = 3'b010,
		ACD_ACQ_STOP = 3'b100
	} acd_acq_e;

	// one decoded command from the host
	typedef struct packed {
		logic [15:0] id;
		logic [15:0] addr;
		logic [31:0] pld;
	} acd_cmd_s;

	// stored settings
	typedef struct packed {
		logic [31:0] mode;
		logic [31:0] scope;
		logic [31:0] fwth;
		logic [31:0] tdc;
		logic [31:0] trgmask;
		acd_acq_e    acq;
	} acd_cfg_s;

	// peripheral strobes
	typedef struct packed {
		logic        adc_wr;
		logic        adc_rst;
		logic        dac_energy_wr;
		logic        dac_timing_wr;
		logic [31:0] data;
		logic        tdc_rst;
		logic        tdc_cal;
		logic        tdc_run;
		logic        acq_flush;
	} acd_per_s;
endpackage

// ### core/acd_exec.sv
// executes one decoded command: settings store and read-back value
// assumes a one-cycle i_go strobe with a stable command beside it
`include "acd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acd_exec (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_sys_rst,
	// command
	input  wire logic             i_go,
	input  wire acd_pkg::acd_cmd_s i_cmd,
	// results
	output logic [31:0]           o_rd_pld,
	output acd_pkg::acd_cfg_s     o_cfg,
	output acd_pkg::acd_per_s     o_per
);
	import acd_pkg::*;

	typedef struct packed {
		acd_cfg_s    cfg;
		acd_per_s    per;
		logic [31:0] rd;
	} acd_ex_s;

	acd_ex_s st_reg;
	acd_ex_s st_next;

	// decode and store
	always_comb begin
		st_next = st_reg;
		st_next.per = '0;
		if (i_go) begin
			st_next.rd = 32'h0000_0000;
			case (i_cmd.id)
				`ACD_CMD_MODE_WR: begin
					// mode from payload, scope or singles
					st_next.cfg.mode = i_cmd.pld;
				end
				`ACD_CMD_MODE_RD: begin
					st_next.rd = st_reg.cfg.mode;
				end
				`ACD_CMD_SCOPE_WR: begin
					st_next.cfg.scope = i_cmd.pld;
				end
				`ACD_CMD_SCOPE_RD: st_next.rd = st_reg.cfg.scope;
				`ACD_CMD_ACTION_WR: begin
					case (i_cmd.pld)
						`ACD_ACT_RESET: begin
							st_next.cfg.acq   = ACD_ACQ_IDLE;
							st_next.cfg.fwth  = '0;
							st_next.cfg.tdc   = '0;
							st_next.per.acq_flush = 1'b1;
						end
						`ACD_ACT_STOP: st_next.cfg.acq = ACD_ACQ_STOP;
						`ACD_ACT_RUN:  st_next.cfg.acq = ACD_ACQ_RUN;
						default: ;
					endcase
				end
				`ACD_CMD_ACTION_RD: st_next.rd = {29'h0000_0000, st_reg.cfg.acq};
				`ACD_CMD_TRGMASK_WR: begin
					st_next.cfg.trgmask = i_cmd.pld;
				end
				`ACD_CMD_TDC_WR: begin
					st_next.cfg.tdc = i_cmd.pld;
					st_next.per.tdc_rst = (i_cmd.pld == `ACD_TDC_RESET);
					st_next.per.tdc_cal = (i_cmd.pld == `ACD_TDC_CALIB);
					st_next.per.tdc_run = (i_cmd.pld == `ACD_TDC_RUN);
				end
				`ACD_CMD_TDC_RD: st_next.rd = st_reg.cfg.tdc;
				`ACD_CMD_ADC_RST: begin
					st_next.per.adc_rst = 1'b1;
				end
				`ACD_CMD_ADC_WR: begin
					st_next.per.adc_wr = 1'b1;
					st_next.per.data   = i_cmd.pld;
				end
				`ACD_CMD_DAC_WR: begin
					st_next.per.data = i_cmd.pld;
					st_next.per.dac_energy_wr = (i_cmd.pld[31:24] == `ACD_DAC_ENERGY_PFX);
					st_next.per.dac_timing_wr = (i_cmd.pld[31:24] == `ACD_DAC_TIMING_PFX);
				end
				`ACD_CMD_FWTH_WR: st_next.cfg.fwth = i_cmd.pld;
				`ACD_CMD_FWTH_RD: st_next.rd = st_reg.cfg.fwth;
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg <= '{cfg: '{mode: 32'h0000_0000, scope: 32'h0000_0000, fwth: 32'h0000_0000,
				tdc: 32'h0000_0000, trgmask: 32'h0000_0000, acq: ACD_ACQ_IDLE},
				per: '0, rd: 32'h0000_0000};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_rd_pld = st_reg.rd;
	assign o_cfg    = st_reg.cfg;
	assign o_per    = st_reg.per;

	property p_run_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_ACTION_WR && i_cmd.pld == `ACD_ACT_RUN)
			|=> (o_cfg.acq == ACD_ACQ_RUN);
	endproperty
	a_run_cmd: assert property (p_run_cmd) else $error("run action not taken");

	property p_stop_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_ACTION_WR && i_cmd.pld == `ACD_ACT_STOP)
			|=> (o_cfg.acq == ACD_ACQ_STOP) && !o_per.acq_flush;
	endproperty
	a_stop_cmd: assert property (p_stop_cmd) else $error("stop action wrong");

	property p_reset_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_ACTION_WR && i_cmd.pld == `ACD_ACT_RESET)
			|=> o_per.acq_flush && o_cfg.fwth == 32'h0000_0000 && !o_per.adc_rst
			&& o_cfg.acq == ACD_ACQ_IDLE;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset action wrong");

	property p_reset_keeps_per;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_ACTION_WR && i_cmd.pld == `ACD_ACT_RESET)
			|=> !o_per.adc_wr && !o_per.dac_energy_wr && !o_per.dac_timing_wr;
	endproperty
	a_reset_keeps_per: assert property (p_reset_keeps_per) else $error("reset hit adc/dac");

	property p_tdc_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_TDC_WR) |=> (o_cfg.tdc == $past(i_cmd.pld))
			&& (o_per.tdc_rst == ($past(i_cmd.pld) == `ACD_TDC_RESET));
	endproperty
	a_tdc_cmd: assert property (p_tdc_cmd) else $error("converter control wrong");

	property p_dac_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_DAC_WR && i_cmd.pld[31:24] == `ACD_DAC_TIMING_PFX)
			|=> o_per.dac_timing_wr && !o_per.dac_energy_wr ##1 !o_per.dac_timing_wr;
	endproperty
	a_dac_cmd: assert property (p_dac_cmd) else $error("dac timing strobe wrong");

	property p_adc_cmd;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_go && i_cmd.id == `ACD_CMD_ADC_WR) |=> o_per.adc_wr && o_per.data == $past(i_cmd.pld);
	endproperty
	a_adc_cmd: assert property (p_adc_cmd) else $error("adc write not forwarded");
endmodule
`default_nettype wire

// ### core/acd_top.sv
// apb front end of the acquisition command decoder
// assumes the network stack writes commands here and reads the reply
//
// Our own choices: register access over APB and the register addresses.
`include "acd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acd_top (
	// clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_sys_rst,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [11:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic [31:0]            o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// settings and strobes
	output acd_pkg::acd_cfg_s      o_cfg,
	output acd_pkg::acd_per_s      o_per,
	// response strobe
	output logic                   o_rsp_valid
);
	import acd_pkg::*;

	typedef struct packed {
		acd_cmd_s    cmd;
		logic [14:0] board_id;
		logic [15:0] rsp_id;
		logic [15:0] rsp_addr;
		logic [2:0]  pend;     // filter, execute, then capture reply
		logic        rsp_done;
		logic        rsp_valid;
		logic        go;
		logic        go_d;     // go one cycle late, lines up with the read-back value
	} acd_top_s;

	acd_top_s    st_reg;
	acd_top_s    st_next;
	logic [31:0] rd_pld;
	logic [31:0] rsp_pld_reg;
	logic        addr_hit;
	logic        wr_acc;
	logic        rd_acc;
	logic        map_hit;

	// broadcast flag or exact board index
	assign addr_hit = st_reg.cmd.addr[`ACD_ADDR_BCAST_BIT]
		|| (st_reg.cmd.addr[`ACD_ADDR_BOARD_MSB:0] == st_reg.board_id);

	assign wr_acc = i_psel && i_penable && i_pwrite;
	assign rd_acc = i_psel && i_penable && !i_pwrite;

	// decode of the map, unmapped answers with pslverr
	always_comb begin
		map_hit  = 1'b1;
		o_prdata = 32'h0000_0000;
		case (i_paddr)
			`ACD_REG_CMD_ID:   o_prdata = {16'h0000, st_reg.cmd.id};
			`ACD_REG_CMD_ADDR: o_prdata = {16'h0000, st_reg.cmd.addr};
			`ACD_REG_CMD_PLD:  o_prdata = st_reg.cmd.pld;
			`ACD_REG_CMD_GO:   o_prdata = 32'h0000_0000;
			`ACD_REG_RSP_ID:   o_prdata = {16'h0000, st_reg.rsp_id};
			`ACD_REG_RSP_ADDR: o_prdata = {16'h0000, st_reg.rsp_addr};
			`ACD_REG_RSP_PLD:  o_prdata = rsp_pld_reg;
			`ACD_REG_STATUS:   o_prdata = {27'h000_0000, o_cfg.acq, st_reg.pend != 3'b000,
				st_reg.rsp_done};
			`ACD_REG_BOARD_ID: o_prdata = {17'h0_0000, st_reg.board_id};
			default:           map_hit = 1'b0;
		endcase
	end

	// zero wait state slave
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && !map_hit;

	// register writes and command sequencing
	always_comb begin
		st_next = st_reg;
		st_next.go = 1'b0;
		st_next.rsp_valid = 1'b0;
		st_next.pend = {st_reg.pend[1:0], 1'b0};
		st_next.go_d = st_reg.go;
		if (wr_acc) begin
			case (i_paddr)
				`ACD_REG_CMD_ID:   st_next.cmd.id   = i_pwdata[15:0];
				`ACD_REG_CMD_ADDR: st_next.cmd.addr = i_pwdata[15:0];
				`ACD_REG_CMD_PLD:  st_next.cmd.pld  = i_pwdata;
				`ACD_REG_CMD_GO: begin
					st_next.pend[0] = 1'b1;
					st_next.rsp_done = 1'b0;
				end
				`ACD_REG_BOARD_ID: st_next.board_id = i_pwdata[14:0];
				default: ;
			endcase
		end
		// address filter gates execution and zeroes the reply payload, reply still goes out
		if (st_reg.pend[0]) begin
			st_next.go = addr_hit;
		end
		if (st_reg.pend[2]) begin
			// echo id, reply address is the fixed ACD_RST_SRC_ADDR
			st_next.rsp_id    = st_reg.cmd.id;
			st_next.rsp_addr  = `ACD_RST_SRC_ADDR;
			st_next.rsp_done  = 1'b1;
			st_next.rsp_valid = 1'b1;
		end
		// reading the reply payload acknowledges it; a new reply wins
		if (rd_acc && i_paddr == `ACD_REG_RSP_PLD && !st_reg.pend[2]) begin
			st_next.rsp_done = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg <= '{cmd: '0, board_id: `ACD_RST_BOARD_ID, rsp_id: 16'h0000,
				rsp_addr: 16'h0000, pend: 3'b000, rsp_done: 1'b0, rsp_valid: 1'b0, go: 1'b0,
				go_d: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// reply payload capture; the executor registers its read-back at the edge after go,
	// so sampling any earlier would hand back the previous command's value
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rsp_pld_reg <= 32'h0000_0000;
		end else if (st_reg.pend[2]) begin
			rsp_pld_reg <= st_reg.go_d ? rd_pld : 32'h0000_0000;
		end
	end

	assign o_rsp_valid = st_reg.rsp_valid;

	acd_exec u_exec (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_go      (st_reg.go),
		.i_cmd     (st_reg.cmd),
		.o_rd_pld  (rd_pld),
		.o_cfg     (o_cfg),
		.o_per     (o_per)
	);

	property p_rsp_after_go;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(wr_acc && i_paddr == `ACD_REG_CMD_GO) |=> ##3 o_rsp_valid;
	endproperty
	a_rsp_after_go: assert property (p_rsp_after_go) else $error("no reply after go");

	property p_bcast;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st_reg.pend[0] && st_reg.cmd.addr[`ACD_ADDR_BCAST_BIT]) |=> st_reg.go;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast not executed");

	property p_mode_rb;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st_reg.go && st_reg.cmd.id == `ACD_CMD_MODE_RD) |=> ##1 rsp_pld_reg == $past(o_cfg.mode, 2);
	endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode read-back wrong");

	c_go:     cover property (@(posedge i_clk_sys) st_reg.go);
	c_rsp:    cover property (@(posedge i_clk_sys) o_rsp_valid);
	c_run:    cover property (@(posedge i_clk_sys) o_cfg.acq == ACD_ACQ_RUN);
	c_unmap:  cover property (@(posedge i_clk_sys) o_pslverr);
endmodule
`default_nettype wire

// ### testbench/acd_host_model.sv
// host-side model: apb master that carries host commands to the decoder
// assumes one clock shared with the decoder and a zero or more wait slave
`timescale 1ns/1ps
`default_nettype none
module acd_host_model #(
	parameter int CAL_CYCLES = 200 // stands in for the calibration wait
) (
	// clock
	input  wire logic        i_clk_sys,
	// apb master
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic [11:0]      o_paddr,
	output logic [31:0]      o_pwdata,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr
);
	// idle bus at time zero
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0000_0000;
	end

	// one transfer; waits for pready, released bus shows inverted values
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge i_clk_sys);
		o_psel <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite <= wr;
		o_paddr <= addr;
		o_pwdata <= wd;
		@(posedge i_clk_sys);
		o_penable <= 1'b1;
		@(posedge i_clk_sys);
		while (i_pready !== 1'b1) @(posedge i_clk_sys);
		rd = i_prdata;
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		o_paddr <= ~addr;
		o_pwdata <= ~wd;
	endtask

	task automatic wait_calib();
		repeat (CAL_CYCLES) @(posedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench: host commands over apb, checks replies, settings, strobes
// assumes acd_top and the host model; expectations come from the constants
`timescale 1ns/1ps
`default_nettype none
`include "acd_defines.svh"
module tb;
	import acd_pkg::*;
	logic        clk_sys;
	logic        sys_rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rsp_valid;
	acd_cfg_s    cfg;
	acd_per_s    per;
	acd_per_s    per_log;
	logic [7:0]  per_stb;
	logic [7:0]  stb_seen;
	logic [31:0] rd;
	logic        er;
	int          err_total;
	int          total_checks;
	int          rsp_cnt;

	acd_top i_acd_top (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_cfg(cfg),
		.o_per(per), .o_rsp_valid(rsp_valid));
	acd_host_model i_acd_host_model (.i_clk_sys(clk_sys), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
		.i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

	// clock at 40 MHz
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// strobe vectors: current cycle and sticky since the last go write
	assign per_stb = {per.adc_wr, per.adc_rst, per.dac_energy_wr, per.dac_timing_wr,
		per.tdc_rst, per.tdc_cal, per.tdc_run, per.acq_flush};
	assign stb_seen = {per_log.adc_wr, per_log.adc_rst, per_log.dac_energy_wr,
		per_log.dac_timing_wr, per_log.tdc_rst, per_log.tdc_cal, per_log.tdc_run,
		per_log.acq_flush};

	// pulses are one cycle wide, so collect them as they pass
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			per_log <= '0;
			rsp_cnt <= 0;
		end else begin
			if (psel && penable && pwrite && paddr == `ACD_REG_CMD_GO)
				per_log <= '0;
			else if (|per_stb)
				per_log <= per_log | per;
			if (rsp_valid === 1'b1)
				rsp_cnt <= rsp_cnt + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		i_acd_host_model.xfer(1'b1, a, d, x, e);
	endtask

	// one command: load, go, wait for reply, check echo, payload and strobes
	task automatic cmd(input logic [15:0] id, input logic [15:0] ad, input logic [31:0] pl,
		input logic [31:0] exp, input logic cp, input logic [7:0] stb);
		int n;
		int c0;
		logic [31:0] d;
		logic e;
		wr(`ACD_REG_CMD_ID, {16'h0000, id});
		wr(`ACD_REG_CMD_ADDR, {16'h0000, ad});
		wr(`ACD_REG_CMD_PLD, pl);
		c0 = rsp_cnt;
		wr(`ACD_REG_CMD_GO, 32'h0000_0001);
		n = 0;
		d = 32'h0000_0000;
		while (d[0] !== 1'b1 && n < 30) begin
			i_acd_host_model.xfer(1'b0, `ACD_REG_STATUS, 32'h0000_0000, d, e);
			n++;
		end
		chk(32'(d[0]), 32'h0000_0001);
		i_acd_host_model.xfer(1'b0, `ACD_REG_RSP_ID, 32'h0000_0000, d, e);
		chk(d, {16'h0000, id});
		i_acd_host_model.xfer(1'b0, `ACD_REG_RSP_ADDR, 32'h0000_0000, d, e);
		chk(d, {16'h0000, `ACD_RST_SRC_ADDR});
		i_acd_host_model.xfer(1'b0, `ACD_REG_RSP_PLD, 32'h0000_0000, d, e);
		if (cp)
			chk(d, exp);
		chk(32'(rsp_cnt - c0), 32'h0000_0001);
		chk({24'h00_0000, stb_seen}, {24'h00_0000, stb});
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// watchdog, well beyond the fewer than a thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		complete_run();
	end

	initial begin
		err_total = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		// reset state and an unmapped address
		i_acd_host_model.xfer(1'b0, `ACD_REG_STATUS, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_0004);
		i_acd_host_model.xfer(1'b0, 12'h024, 32'h0000_0000, rd, er);
		chk(rd, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		$display("test reset done");
		// mode set and read-back, other board too
		cmd(`ACD_CMD_MODE_WR, 16'h8003, `ACD_MODE_SCOPE, 0, 0, 8'h00);
		chk(cfg.mode, `ACD_MODE_SCOPE);
		cmd(`ACD_CMD_MODE_RD, 16'h8001, 0, `ACD_MODE_SCOPE, 1, 8'h00);
		cmd(`ACD_CMD_MODE_WR, 16'h8003, `ACD_MODE_SINGLES, 0, 0, 8'h00);
		chk(cfg.mode, `ACD_MODE_SINGLES);
		cmd(`ACD_CMD_MODE_RD, 16'h8003, 0, `ACD_MODE_SINGLES, 1, 8'h00);
		$display("test mode done");
		cmd(`ACD_CMD_SCOPE_WR, 16'h8003, 32'h0200_0101, 0, 0, 8'h00);
		cmd(`ACD_CMD_SCOPE_RD, 16'h8003, 0, 32'h0200_0101, 1, 8'h00);
		chk(32'(cfg.scope[`ACD_SCP_SMP_LSB +: 4]) * `ACD_SCP_SMP_UNIT, 32'd16);
		chk(32'(cfg.scope[`ACD_SCP_BTG_LSB +: 4]), 32'd0);
		chk(32'(cfg.scope[`ACD_SCP_WIN_LSB +: 4]), 32'd2);
		cmd(`ACD_CMD_FWTH_WR, 16'h8003, 32'h0000_1234, 0, 0, 8'h00);
		cmd(`ACD_CMD_FWTH_RD, 16'h8003, 0, 32'h0000_1234, 1, 8'h00);
		cmd(`ACD_CMD_TRGMASK_WR, 16'h8003, 32'h0FFF_FFFF, 0, 0, 8'h00);
		chk(cfg.trgmask, 32'h0FFF_FFFF);
		$display("test settings done");
		cmd(`ACD_CMD_TDC_WR, 16'h8003, `ACD_TDC_RESET, 0, 0, 8'h08);
		cmd(`ACD_CMD_TDC_WR, 16'h8003, `ACD_TDC_CALIB, 0, 0, 8'h04);
		i_acd_host_model.wait_calib();
		cmd(`ACD_CMD_TDC_WR, 16'h8003, `ACD_TDC_RUN, 0, 0, 8'h02);
		cmd(`ACD_CMD_TDC_RD, 16'h8003, 0, `ACD_TDC_RUN, 1, 8'h00);
		chk(cfg.tdc, `ACD_TDC_RUN);
		cmd(`ACD_CMD_ADC_WR, 16'h8006, 32'h8114_0001, 0, 0, 8'h80);
		chk(per_log.data, 32'h8114_0001);
		cmd(`ACD_CMD_ADC_RST, 16'h8003, 0, 0, 0, 8'h40);
		cmd(`ACD_CMD_DAC_WR, 16'h8003, 32'h8007_E032, 0, 0, 8'h20);
		chk(per_log.data, 32'h8007_E032);
		cmd(`ACD_CMD_DAC_WR, 16'h8003, 32'h8807_E000, 0, 0, 8'h10);
		$display("test peripherals done");
		cmd(`ACD_CMD_ACTION_WR, 16'h8003, `ACD_ACT_RUN, 0, 0, 8'h00);
		chk(32'(cfg.acq), 32'(ACD_ACQ_RUN));
		cmd(`ACD_CMD_ACTION_RD, 16'h8003, 0, 32'(ACD_ACQ_RUN), 1, 8'h00);
		cmd(`ACD_CMD_ACTION_WR, 16'h8003, `ACD_ACT_STOP, 0, 0, 8'h00);
		chk(32'(cfg.acq), 32'(ACD_ACQ_STOP));
		chk(cfg.fwth, 32'h0000_1234);
		cmd(`ACD_CMD_ACTION_WR, 16'h8003, `ACD_ACT_RESET, 0, 0, 8'h01);
		chk(32'(cfg.acq), 32'(ACD_ACQ_IDLE));
		chk(cfg.fwth, 32'h0000_0000);
		chk(cfg.tdc, 32'h0000_0000);
		$display("test action done");
		cmd(`ACD_CMD_FWTH_WR, 16'h0003, 32'h0000_0055, 0, 1, 8'h00);
		chk(cfg.fwth, 32'h0000_0000);
		wr(`ACD_REG_BOARD_ID, 32'h0000_0003);
		cmd(`ACD_CMD_FWTH_WR, 16'h0003, 32'h0000_0055, 0, 0, 8'h00);
		cmd(`ACD_CMD_FWTH_RD, 16'h0003, 0, 32'h0000_0055, 1, 8'h00);
		$display("test address done");
		complete_run();
	end
endmodule
`default_nettype wire
